// ===== core/flash_cfg_regs.sv
`timescale 1ns/1ps
// Operation
// - boot start address, 32-byte aligned, default zero
// - boot delay field sets initial cycles
// - zero delay gives 8 or 6
// - bit0 enables boot-on-select, default off
// - two bank bits select 128Mb segment
// - three-byte mode prepends bank bits
// - wide mode ignores bank bits
// - bank bit7 selects address width
// - bank read/write opcodes, reserved read zero
// - enter/exit wide address opcodes
// - protection config read/program, default ones
// - bit1 zero locks persistent mode
// - bit2 zero locks password mode
// - bit15 places parameter sectors
// - both locks zero aborts, flags error
// - locks frozen once one programmed
// - parameter bit returns to one only on reset
module flash_cfg_regs
    import boot_bank_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    flash_link_if.dev link,
    input wire logic quad_enable,
    output logic [31:0] array_addr,
    output logic array_addr_vld,
    output logic program_error,
    output logic [7:0] boot_byte_addr
);
    // ****************************************
    // pin sync and sck edges
    // ****************************************
    logic [1:0] sck_s_ff, cs_s_ff, mosi_s_ff;
    logic sck_d_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s_ff <= 2'h0;
            cs_s_ff <= 2'h3;
            mosi_s_ff <= 2'h0;
            sck_d_ff <= 1'b0;
        end else begin
            sck_s_ff <= {sck_s_ff[0], link.sck};
            cs_s_ff <= {cs_s_ff[0], link.cs_n};
            mosi_s_ff <= {mosi_s_ff[0], link.mosi};
            sck_d_ff <= sck_s_ff[1];
        end
    end
    logic rise, fall, sel;
    assign rise = sck_s_ff[1] & ~sck_d_ff;
    assign fall = ~sck_s_ff[1] & sck_d_ff;
    assign sel = ~cs_s_ff[1];

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] boot_config_ff;
    logic [7:0] bank_v_ff, bank_nv_ff;
    logic [15:0] prot_ff;
    logic perr_ff;
    logic [3:0] boot_delay;
    logic [7:0] bank_rd;
    assign boot_delay = (boot_config_ff[4:BOOT_DELAY_LSB] == 4'h0) ?
        (quad_enable ? DELAY_QE1 : DELAY_QE0) : boot_config_ff[4:BOOT_DELAY_LSB];
    assign bank_rd = bank_v_ff & BANK_WRITE_MASK;

    // ****************************************
    // link engine
    // ****************************************
    logic [7:0] op_ff;
    logic [31:0] sh_ff, out_ff;
    logic [6:0] bits_ff;
    logic boot_mode_ff, was_sel_ff;
    logic [3:0] dly_ff;
    logic [31:0] boot_ptr_ff;
    logic [5:0] need;
    logic op_done;
    logic [7:0] opn;
    assign opn = sh_ff[7:0];
    always_comb begin
        unique case (op_ff)
            OP_WRITE_BANK_V_A, OP_WRITE_BANK_V_B, OP_WRITE_BANK_NV: need = 6'd16;
            OP_PROG_PROT: need = 6'd24;
            OP_WRITE_BOOT: need = 6'd40;
            // wide mode takes four address bytes
            OP_ARRAY_READ: need = bank_v_ff[BANK_WIDE_BIT] ? 6'd40 : 6'd32;
            default: need = 6'd8;
        endcase
    end
    assign op_done = rise & (bits_ff == 7'(need) - 7'd1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_ff <= 8'h00;
            sh_ff <= 32'h0;
            bits_ff <= 7'h0;
            was_sel_ff <= 1'b0;
            boot_mode_ff <= 1'b0;
            dly_ff <= 4'h0;
        end else begin
            was_sel_ff <= sel;
            if (!sel) begin
                bits_ff <= 7'h0;
                boot_mode_ff <= 1'b0;
            end else if (sel && !was_sel_ff) begin
                boot_mode_ff <= boot_config_ff[BOOT_EN_BIT];
                dly_ff <= boot_delay;
            end else if (rise) begin
                sh_ff <= {sh_ff[30:0], mosi_s_ff[1]};
                if (bits_ff != 7'h7f)
                    bits_ff <= bits_ff + 7'd1;
                if (bits_ff == 7'd7)
                    op_ff <= {sh_ff[6:0], mosi_s_ff[1]};
                if (boot_mode_ff && dly_ff != 4'h0)
                    dly_ff <= dly_ff - 4'd1;
            end
        end
    end

    logic [7:0] nxt_byte;
    always_comb begin
        nxt_byte = {sh_ff[6:0], mosi_s_ff[1]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_config_ff <= BOOT_RESET;
            bank_v_ff <= BANK_RESET;
            bank_nv_ff <= BANK_RESET;
            prot_ff <= PROT_RESET;
            perr_ff <= 1'b0;
        end else if (sel && !boot_mode_ff) begin
            if (rise && bits_ff == 7'd7) begin
                unique case (nxt_byte)
                    OP_ENTER_WIDE: bank_v_ff[BANK_WIDE_BIT] <= 1'b1;
                    OP_EXIT_WIDE: bank_v_ff[BANK_WIDE_BIT] <= 1'b0;
                    OP_CLEAR_ERR: perr_ff <= 1'b0;
                    default: ;
                endcase
            end else if (op_done) begin
                unique case (op_ff)
                    OP_WRITE_BANK_V_A, OP_WRITE_BANK_V_B:
                        bank_v_ff <= nxt_byte & BANK_WRITE_MASK;
                    OP_WRITE_BANK_NV: begin
                        bank_nv_ff <= nxt_byte & BANK_WRITE_MASK;
                        bank_v_ff <= nxt_byte & BANK_WRITE_MASK;
                    end
                    OP_WRITE_BOOT: boot_config_ff <= {sh_ff[30:0], mosi_s_ff[1]};
                    OP_PROG_PROT: begin
                        if (sh_ff[1:0] == 2'b00) begin
                            perr_ff <= 1'b1;
                        end else begin
                            if (prot_ff[2:1] != 2'b11 && sh_ff[1:0] != prot_ff[2:1])
                                perr_ff <= 1'b1;
                            else if (prot_ff[2:1] == 2'b11)
                                prot_ff[2:1] <= sh_ff[1:0];
                            prot_ff[PROT_PARAM_LOC_BIT] <=
                                prot_ff[PROT_PARAM_LOC_BIT] & sh_ff[14];
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // ****************************************
    // read data and boot stream
    // ****************************************
    logic [31:0] nxt_out;
    always_comb begin
        unique case (nxt_byte)
            OP_READ_BANK_A, OP_READ_BANK_B: nxt_out = {bank_rd, 24'h0};
            OP_READ_PROT: nxt_out = {prot_ff, 16'h0};
            OP_READ_BOOT: nxt_out = boot_config_ff;
            OP_READ_ERR: nxt_out = {7'h0, perr_ff, 24'h0};
            default: nxt_out = 32'h0;
        endcase
    end

    logic miso_ff, oe_ff, vld_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 32'h0;
            miso_ff <= 1'b0;
            oe_ff <= 1'b0;
            boot_ptr_ff <= 32'h0;
            array_addr <= 32'h0;
            vld_ff <= 1'b0;
        end else begin
            vld_ff <= 1'b0;
            if (!sel) begin
                oe_ff <= 1'b0;
            end else if (sel && !was_sel_ff) begin
                boot_ptr_ff <= {boot_config_ff[31:BOOT_ADDR_LSB], 5'h0};
            end else if (boot_mode_ff) begin
                if (fall && dly_ff == 4'h0) begin
                    oe_ff <= 1'b1;
                    miso_ff <= 1'b0;
                    if (!oe_ff) begin
                        array_addr <= boot_ptr_ff;
                        vld_ff <= 1'b1;
                    end
                end
                // bytes count from data start; quad_enable must hold during a frame
                if (rise && oe_ff && bits_ff[2:0] == 3'(boot_delay - 4'd1))
                    boot_ptr_ff <= boot_ptr_ff + 32'h1;
            end else if (rise && bits_ff == 7'd7) begin
                out_ff <= nxt_out;
            end else if (fall && bits_ff >= 7'd8 && op_ff != OP_ARRAY_READ) begin
                oe_ff <= 1'b1;
                miso_ff <= out_ff[31];
                out_ff <= {out_ff[30:0], 1'b0};
            end else if (op_done && op_ff == OP_ARRAY_READ) begin
                vld_ff <= 1'b1;
                if (!bank_v_ff[BANK_WIDE_BIT])
                    array_addr <= {6'h0, bank_v_ff[1:0], sh_ff[22:0], mosi_s_ff[1]};
                else
                    array_addr <= {sh_ff[30:0], mosi_s_ff[1]};
            end
        end
    end
    assign link.miso = miso_ff;
    assign link.miso_oe = oe_ff;
    assign array_addr_vld = vld_ff;
    assign program_error = perr_ff;
    assign boot_byte_addr = boot_ptr_ff[7:0];
endmodule

// ===== core/flash_host_ctrl.sv
`timescale 1ns/1ps
module flash_host_ctrl
    import boot_bank_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    flash_link_if.host link
);
    // ****************************************
    // apb registers
    // ****************************************
    logic [31:0] rd_ff, wdata_ff, addr_ff, prdata_ff;
    logic [7:0] div_ff, op_ff;
    logic [5:0] nbits_ff;
    logic busy_ff, start;
    logic [1:0] miso_s_ff;
    logic acc;
    assign acc = psel & penable;
    assign start = acc & pwrite & (paddr == REG_CMD) & ~busy_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdata_ff <= 32'h0;
            addr_ff <= 32'h0;
            div_ff <= DIV_RESET;
            prdata_ff <= 32'h0;
            op_ff <= 8'h0;
            nbits_ff <= 6'h0;
        end else begin
            if (acc && pwrite) begin
                unique case (paddr)
                    REG_CMD: if (!busy_ff) begin
                        op_ff <= pwdata[7:0];
                        nbits_ff <= pwdata[13:8];
                    end
                    REG_WDATA: wdata_ff <= pwdata;
                    REG_ADDR: addr_ff <= pwdata;
                    REG_DIV: div_ff <= (pwdata[7:0] == 8'h0) ? 8'h1 : pwdata[7:0];
                    default: ;
                endcase
            end
            // loaded in setup so read data stands through access
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    REG_RDATA: prdata_ff <= rd_ff;
                    REG_STATUS: prdata_ff <= {31'h0, busy_ff};
                    REG_DIV: prdata_ff <= {24'h0, div_ff};
                    default: prdata_ff <= 32'h0;
                endcase
            end
        end
    end
    assign prdata = prdata_ff;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    // ****************************************
    // link shifter, mode 0
    // ****************************************
    // command byte then nbits of wdata msb first; miso captured
    logic [7:0] cnt_ff;
    logic sck_ff, cs_ff, mosi_ff;
    logic [39:0] sh_ff;
    logic [6:0] left_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 1'b0;
            cnt_ff <= 8'h0;
            sck_ff <= 1'b0;
            cs_ff <= 1'b1;
            mosi_ff <= 1'b0;
            sh_ff <= 40'h0;
            left_ff <= 7'h0;
            rd_ff <= 32'h0;
            miso_s_ff <= 2'h0;
        end else begin
            miso_s_ff <= {miso_s_ff[0], link.miso};
            if (start) begin
                busy_ff <= 1'b1;
                cs_ff <= 1'b0;
                cnt_ff <= 8'h0;
                sh_ff <= {pwdata[7:0], wdata_ff};
                mosi_ff <= pwdata[7];
                left_ff <= 7'd8 + {1'b0, pwdata[13:8]};
            end else if (busy_ff) begin
                if (cnt_ff + 8'd1 >= div_ff) begin
                    cnt_ff <= 8'h0;
                    if (!sck_ff) begin
                        sck_ff <= 1'b1;
                    end else begin
                        // miso taken late: both ends' syncs eat the low phase
                        sck_ff <= 1'b0;
                        rd_ff <= {rd_ff[30:0], miso_s_ff[1]};
                        sh_ff <= {sh_ff[38:0], 1'b0};
                        mosi_ff <= sh_ff[38];
                        left_ff <= left_ff - 7'd1;
                        if (left_ff == 7'd1) begin
                            busy_ff <= 1'b0;
                            cs_ff <= 1'b1;
                        end
                    end
                end else begin
                    cnt_ff <= cnt_ff + 8'd1;
                end
            end
        end
    end
    assign link.sck = sck_ff;
    assign link.cs_n = cs_ff;
    assign link.mosi = mosi_ff;
endmodule

// ===== inc/boot_bank_pkg.sv
package boot_bank_pkg;
    // ****************************************
    // opcodes
    // ****************************************
    localparam logic [7:0] OP_READ_BANK_A = 8'h16;
    localparam logic [7:0] OP_READ_BANK_B = 8'hc8;
    localparam logic [7:0] OP_WRITE_BANK_V_A = 8'h17;
    localparam logic [7:0] OP_WRITE_BANK_V_B = 8'hc5;
    localparam logic [7:0] OP_WRITE_BANK_NV = 8'h18;
    localparam logic [7:0] OP_ENTER_WIDE = 8'hb7;
    localparam logic [7:0] OP_EXIT_WIDE = 8'h29;
    localparam logic [7:0] OP_READ_PROT = 8'h2b;
    localparam logic [7:0] OP_PROG_PROT = 8'h2f;
    localparam logic [7:0] OP_READ_BOOT = 8'h14;
    localparam logic [7:0] OP_WRITE_BOOT = 8'h15;
    localparam logic [7:0] OP_READ_ERR = 8'h81;
    localparam logic [7:0] OP_CLEAR_ERR = 8'h82;
    localparam logic [7:0] OP_ARRAY_READ = 8'h03;
    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int BOOT_ADDR_LSB = 5;
    localparam int BOOT_DELAY_LSB = 1;
    localparam int BOOT_EN_BIT = 0;
    localparam int BANK_WIDE_BIT = 7;
    localparam int PROT_PERSIST_BIT = 1;
    localparam int PROT_PASSWORD_BIT = 2;
    localparam int PROT_PARAM_LOC_BIT = 15;
    localparam logic [31:0] BOOT_RESET = 32'h0000_0000;
    localparam logic [7:0] BANK_RESET = 8'h00;
    localparam logic [7:0] BANK_WRITE_MASK = 8'h83;
    localparam logic [15:0] PROT_RESET = 16'hffff;
    localparam logic [3:0] DELAY_QE0 = 4'h8;
    localparam logic [3:0] DELAY_QE1 = 4'h6;
    // ****************************************
    // host apb map
    // ****************************************
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_RDATA = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_DIV = 8'h14;
    localparam logic [7:0] DIV_RESET = 8'h04;
endpackage

// ===== inc/flash_link_if.sv
`timescale 1ns/1ps
interface flash_link_if;
    logic sck;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport dev (input sck, input cs_n, input mosi, output miso, output miso_oe);
    modport host (output sck, output cs_n, output mosi, input miso, input miso_oe);
endinterface

// ===== tb/link_props.sv
`timescale 1ns/1ps
module link_props
    import boot_bank_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic [31:0] array_addr,
    input wire logic array_addr_vld,
    input wire logic program_error
);
    // ************
    // frame decode
    // ************
    logic sck_d_ff;
    logic [6:0] cnt_ff;
    logic [31:0] shift_ff;
    logic [7:0] op_ff;
    logic wide_ff;
    logic [1:0] bank_ff;
    logic rise;
    logic rd_bank;
    logic rd_prot;
    assign rise = sck && !sck_d_ff && !cs_n;
    assign rd_bank = rise && (op_ff == OP_READ_BANK_A || op_ff == OP_READ_BANK_B);
    assign rd_prot = rise && op_ff == OP_READ_PROT;
    // raw sck seen here runs ahead of the device's synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_d_ff <= 1'b0;
            cnt_ff <= 7'h00;
            shift_ff <= 32'h0;
            op_ff <= 8'h00;
        end else begin
            sck_d_ff <= sck;
            if (cs_n) begin
                cnt_ff <= 7'h00;
            end else if (rise) begin
                cnt_ff <= cnt_ff + 7'h01;
                shift_ff <= {shift_ff[30:0], mosi};
                if (cnt_ff == 7'h07) begin
                    op_ff <= {shift_ff[6:0], mosi};
                end
            end
        end
    end
    // mirror of width and bank, updated at frame end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_ff <= 1'b0;
            bank_ff <= 2'h0;
        end else if ($rose(cs_n) && op_ff == OP_ENTER_WIDE) begin
            wide_ff <= 1'b1;
        end else if ($rose(cs_n) && op_ff == OP_EXIT_WIDE) begin
            wide_ff <= 1'b0;
        end else if ($rose(cs_n) && cnt_ff == 7'h10 &&
                     op_ff inside {OP_WRITE_BANK_V_A, OP_WRITE_BANK_V_B, OP_WRITE_BANK_NV}) begin
            wide_ff <= shift_ff[7];
            bank_ff <= shift_ff[1:0];
        end
    end
    // ************
    // assertions
    // ************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence array_hit;
        array_addr_vld && op_ff == OP_ARRAY_READ;
    endsequence
    sequence both_locks;
        $rose(cs_n) && op_ff == OP_PROG_PROT && cnt_ff == 7'h18 && shift_ff[2:1] == 2'b00;
    endsequence
    a_bank_resv_zero:
        assert property (rd_bank && cnt_ff inside {[7'h09:7'h0d]} |-> !miso)
        else $error("bank reserved bit read as one");
    a_bank_read_wide:
        assert property (rd_bank && cnt_ff == 7'h08 |-> miso == wide_ff)
        else $error("bank width bit mismatch");
    a_bank_read_seg:
        assert property (rd_bank && cnt_ff inside {7'h0e, 7'h0f} |->
            miso == (cnt_ff[0] ? bank_ff[0] : bank_ff[1]))
        else $error("bank segment bit mismatch");
    a_prot_resv_one:
        assert property (rd_prot && (cnt_ff inside {[7'h09:7'h14]} || cnt_ff == 7'h17) |-> miso)
        else $error("protection reserved bit read as zero");
    a_read_drives:
        assert property ((rd_bank || rd_prot) && cnt_ff >= 7'h08 |-> miso_oe)
        else $error("read data not driven");
    a_idle_quiet:
        assert property (cs_n [*4] |-> !miso_oe)
        else $error("data line driven while deselected");
    a_narrow_addr:
        assert property (array_hit ##0 !wide_ff |->
            array_addr == {6'h00, bank_ff, shift_ff[23:0]})
        else $error("three byte address not extended by bank");
    a_wide_addr:
        assert property (array_hit ##0 wide_ff |-> array_addr == shift_ff)
        else $error("four byte address altered");
    a_err_both_locks:
        assert property (both_locks |-> ##[0:1000] program_error)
        else $error("both locks programmed without error");
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import boot_bank_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic quad_enable = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] array_addr;
    logic array_addr_vld;
    logic program_error;
    logic [31:0] rd;
    logic [31:0] seen = 32'h0;
    logic [7:0] boot_byte;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;
    flash_link_if flash_link_if_i();
    flash_host_ctrl flash_host_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(flash_link_if_i));
    flash_cfg_regs flash_cfg_regs_i (.pclk(pclk), .presetn(presetn), .link(flash_link_if_i),
        .quad_enable(quad_enable), .array_addr(array_addr), .array_addr_vld(array_addr_vld),
        .program_error(program_error), .boot_byte_addr(boot_byte));
    link_props link_props_i (.pclk(pclk), .presetn(presetn), .sck(flash_link_if_i.sck),
        .cs_n(flash_link_if_i.cs_n), .mosi(flash_link_if_i.mosi), .miso(flash_link_if_i.miso),
        .miso_oe(flash_link_if_i.miso_oe), .array_addr(array_addr),
        .array_addr_vld(array_addr_vld), .program_error(program_error));
    always #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (array_addr_vld === 1'b1) begin
            seen <= array_addr;
        end
        if (cycles == 60000) begin
            bad_count++;
            stop_test();
        end
    end
    // ************
    // helpers
    // ************
    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", bad_count, checked);
        if (bad_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // entered just after an edge; an idle edge follows release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // payload sits msb first from bit 31
    task automatic frame(input logic [7:0] op, input int nb, input logic [31:0] d);
        int n;
        apb(1'b1, REG_WDATA, d << (32 - nb));
        apb(1'b1, REG_CMD, {18'h0, 6'(nb), op});
        for (n = 0; n < 100 && flash_link_if_i.cs_n !== 1'b0; n++) @(posedge pclk);
        if (n == 100) bad_count++;
        for (n = 0; n < 3000 && flash_link_if_i.cs_n !== 1'b1; n++) @(posedge pclk);
        if (n == 3000) bad_count++;
        rd = 32'h1;
        for (n = 0; n < 50 && rd[0] !== 1'b0; n++) apb(1'b0, REG_STATUS, 32'h0);
        if (n == 50) bad_count++;
        apb(1'b0, REG_RDATA, 32'h0);
    endtask
    task automatic prog(input logic [15:0] v, input logic [15:0] exp, input logic err);
        frame(OP_PROG_PROT, 16, {16'h0, v});
        check(program_error, err);
        frame(OP_READ_ERR, 8, 32'h0);
        check(rd[7:0], {7'h0, err});
        frame(OP_READ_PROT, 16, 32'h0);
        check(rd[15:0], exp);
        frame(OP_CLEAR_ERR, 0, 32'h0);
    endtask
    // ************
    // scenarios
    // ************
    task automatic t_defaults();
        frame(OP_READ_BOOT, 32, 32'h0);
        check(rd, BOOT_RESET);
        frame(OP_READ_PROT, 16, 32'h0);
        check(rd[15:0], PROT_RESET);
        apb(1'b0, 8'h3c, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, REG_DIV, 32'h0);
        check(rd, {24'h0, DIV_RESET});
    endtask
    task automatic t_boot();
        frame(OP_WRITE_BOOT, 32, 32'h1234_566a);
        frame(OP_READ_BOOT, 32, 32'h0);
        check(rd, 32'h1234_566a);
    endtask
    task automatic t_bank();
        logic [7:0] wop [3] = '{OP_WRITE_BANK_V_A, OP_WRITE_BANK_V_B, OP_WRITE_BANK_NV};
        logic [7:0] wv [3] = '{8'hff, 8'h01, 8'h82};
        frame(OP_READ_BANK_B, 8, 32'h0);
        check(rd[7:0], BANK_RESET);
        for (int i = 0; i < 3; i++) begin
            frame(wop[i], 8, {24'h0, wv[i]});
            frame(i[0] ? OP_READ_BANK_B : OP_READ_BANK_A, 8, 32'h0);
            check(rd[7:0], wv[i] & BANK_WRITE_MASK);
        end
    endtask
    task automatic t_addr();
        frame(OP_EXIT_WIDE, 0, 32'h0);
        frame(OP_READ_BANK_A, 8, 32'h0);
        check(rd[7:0], 8'h02);
        frame(OP_ARRAY_READ, 24, 32'h0012_3456);
        check(seen, 32'h0212_3456);
        frame(OP_ENTER_WIDE, 0, 32'h0);
        frame(OP_READ_BANK_A, 8, 32'h0);
        check(rd[7:0], 8'h82);
        frame(OP_ARRAY_READ, 32, 32'h0765_4321);
        check(seen, 32'h0765_4321);
    endtask
    task automatic t_prot();
        prog(16'hfff8, 16'hffff, 1'b1);
        prog(16'hfffd, 16'hfffd, 1'b0);
        prog(16'hfffb, 16'hfffd, 1'b1);
        prog(16'h0005, 16'h7ffd, 1'b0);
        prog(16'hfffd, 16'h7ffd, 1'b0);
        // second reset restores the lock bits for the other mode
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        prog(16'hfffb, 16'hfffb, 1'b0);
        prog(16'hfffd, 16'hfffb, 1'b1);
    endtask
    // boot stays on once enabled, so this runs last
    task automatic t_stream();
        frame(OP_WRITE_BOOT, 32, 32'h0000_0141);
        quad_enable <= 1'b1;
        frame(8'h00, 6, 32'h0);
        check(seen, 32'h0000_0140);
        check({24'h0, boot_byte}, 32'h0000_0041);
        quad_enable <= 1'b0;
        frame(8'h00, 6, 32'h0);
        check({24'h0, boot_byte}, 32'h0000_0040);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_defaults();
        t_boot();
        t_bank();
        t_addr();
        t_prot();
        t_stream();
        stop_test();
    end
endmodule
